// ==== pbps_top.sv ====
// Pushbutton power sequencer control logic
`timescale 1ns/1ps
`default_nettype none
`include "pbps_map.svh"

module pbps_top #(
  parameter logic [19:0] DEB_TICKS  = 20'(`PBPS_DEB_TICKS),
  parameter logic [19:0] PG_TICKS   = 20'(`PBPS_PG_TICKS),
  parameter logic [19:0] LONG_TICKS = 20'(`PBPS_LONG_TICKS),
  parameter logic [19:0] SEQ_TICKS  = 20'(`PBPS_SEQ_TICKS)
) (
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_I,
  input  wire logic       BUTTON_N_I,
  input  wire logic       HOLD_POWER_IN_I,
  input  wire logic       RAIL3_SWITCH_ENABLE_I,
  input  wire logic       ADAPTER_DETECT_I,
  input  wire logic       OVERVOLTAGE_SENSE_IN_I,
  input  wire logic       RAIL_ONE_IN_REG_I,
  input  wire logic       RAIL_TWO_IN_REG_I,
  input  wire logic       ALWAYS_ON_IN_REG_I,
  input  wire logic       LOGIC_SUPPLY_UV_I,
  input  wire logic       UNDERVOLTAGE_LOCKOUT_I,
  input  wire logic       INPUT_LIMIT_SEL0_I,
  input  wire logic       INPUT_LIMIT_SEL1_I,
  input  wire logic       SERIAL_CLK_I,
  input  wire logic       SERIAL_DATA_I,
  input  wire logic [1:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  output logic      [7:0] REG_RDATA_O,
  output logic            SWITCHED_LINEAR_EN_O,
  output logic            RAIL_ONE_EN_O,
  output logic            RAIL_TWO_EN_O,
  output logic            RAIL_THREE_EN_O,
  output logic            ALWAYS_ON_LINEAR_EN_O,
  output logic            BUTTON_STAT_O,
  output logic            BUTTON_STAT_OE_O,
  output logic            RAILS_GOOD_O,
  output logic            RAILS_GOOD_OE_O,
  output logic            ADAPTER_PRESENT_N_O,
  output logic            USB_PATH_OPEN_O,
  output logic            INPUT_PASS_GATE_O,
  output logic      [1:0] INPUT_LIMIT_SEL_O
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [19:0] sat_inc(input logic [19:0] v);
    sat_inc = (v == 20'hfffff) ? v : v + 20'h1;
  endfunction

  logic [`PBPS_NPINS-1:0] pins, s1_r, s2_r, s3_r, f_r;
  logic [9:0]  tick_cnt_r;
  logic        tick;
  logic [19:0] btn_cnt_r, rel_cnt_r, hold_hi_r, hold_lo_r;
  logic [19:0] seq_cnt_r, pg_cnt_r, pw_cnt_r;
  logic        stat_r, good_r, rst_pulse_r, long_done_r;
  logic        sw_en_r, r1_en_r, r2_en_r, r3_en_r, ao_en_r;
  logic        adapt_n_r, usb_open_r;
  logic [1:0]  sel_r;
  logic [7:0]  ctrl_r, ser_r, shift_r, rdata_r;
  logic [3:0]  bit_cnt_r;
  logic        scl_prev_r;
  logic        regs_ok, start_req, stop_req;
  pbps_pkg::pbps_state_type state_r;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pins = {SERIAL_DATA_I, SERIAL_CLK_I, INPUT_LIMIT_SEL1_I,
                 INPUT_LIMIT_SEL0_I, UNDERVOLTAGE_LOCKOUT_I,
                 LOGIC_SUPPLY_UV_I, ALWAYS_ON_IN_REG_I,
                 RAIL_TWO_IN_REG_I, RAIL_ONE_IN_REG_I,
                 OVERVOLTAGE_SENSE_IN_I, ADAPTER_DETECT_I,
                 RAIL3_SWITCH_ENABLE_I, HOLD_POWER_IN_I, BUTTON_N_I};

  // Three stages, accept when stages two and three agree
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      s1_r <= 14'h0001;
      s2_r <= 14'h0001;
      s3_r <= 14'h0001;
      f_r  <= 14'h0001;  // Button idles released
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < `PBPS_NPINS; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          f_r[i] <= s3_r[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  // [RULE_19] single free-running tick
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      tick_cnt_r <= 10'h000;
    end else if (tick) begin
      tick_cnt_r <= 10'h000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 10'h001;
    end
  end
  assign tick = (tick_cnt_r == 10'(`PBPS_TICK_CYC - 1));

  // ----------------------------------------------------------------
  // Button debounce and long press
  // ----------------------------------------------------------------
  // [RULE_03] low level counts as pressed
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || f_r[`PBPS_P_BTN_N]) begin
      btn_cnt_r <= 20'h00000;
    end else if (tick) begin
      btn_cnt_r <= sat_inc(btn_cnt_r);
    end
  end

  // Release qualification
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || !f_r[`PBPS_P_BTN_N]) begin
      rel_cnt_r <= 20'h00000;
    end else if (tick) begin
      rel_cnt_r <= sat_inc(rel_cnt_r);
    end
  end

  // [RULE_04] debounced button status
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      stat_r <= 1'b0;
    end else if (btn_cnt_r >= DEB_TICKS) begin
      stat_r <= 1'b1;
    end else if (rel_cnt_r >= 20'(`PBPS_REL_TICKS)) begin
      stat_r <= 1'b0;
    end
  end

  // [RULE_16] long press count and reset pulse
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rst_pulse_r <= 1'b0;
      long_done_r <= 1'b0;
      pw_cnt_r    <= 20'h00000;
    end else if (rst_pulse_r) begin
      if (tick) begin
        pw_cnt_r <= pw_cnt_r + 20'h00001;
      end
      if (tick && pw_cnt_r == 20'(`PBPS_RSTPW_TICKS - 1)) begin
        rst_pulse_r <= 1'b0;
      end
    end else if (f_r[`PBPS_P_BTN_N]) begin
      long_done_r <= 1'b0;
    end else if (!long_done_r && btn_cnt_r >= LONG_TICKS) begin
      rst_pulse_r <= 1'b1;
      long_done_r <= 1'b1;
      pw_cnt_r    <= 20'h00000;
    end
  end

  // ----------------------------------------------------------------
  // Hold-power qualification
  // ----------------------------------------------------------------
  // [RULE_19] restart when condition broken
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || !f_r[`PBPS_P_HOLD]) begin
      hold_hi_r <= 20'h00000;
    end else if (tick) begin
      hold_hi_r <= sat_inc(hold_hi_r);
    end
  end

  // [RULE_17] hold-power low timer
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || f_r[`PBPS_P_HOLD]) begin
      hold_lo_r <= 20'h00000;
    end else if (tick) begin
      hold_lo_r <= sat_inc(hold_lo_r);
    end
  end

  // [RULE_15] button held low long enough
  assign start_req = (btn_cnt_r >= DEB_TICKS) || (hold_hi_r >= DEB_TICKS);
  // [RULE_01] dropping hold-power ends the session
  assign stop_req  = (hold_lo_r >= DEB_TICKS) || ctrl_r[`PBPS_CTRL_SOFTOFF];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // [RULE_02] fixed enable order
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || f_r[`PBPS_P_UNDERVOLTAGE_LOCKOUT]) begin
      state_r   <= pbps_pkg::PBPS_OFF;
      seq_cnt_r <= 20'h00000;
      sw_en_r   <= 1'b0;
      r1_en_r   <= 1'b0;
      r2_en_r   <= 1'b0;
    end else begin
      unique case (state_r)
        pbps_pkg::PBPS_OFF: begin
          seq_cnt_r <= 20'h00000;
          if (start_req && !ctrl_r[`PBPS_CTRL_SOFTOFF]) begin
            state_r <= pbps_pkg::PBPS_UP_SW;
            sw_en_r <= 1'b1;
          end
        end
        // [RULE_18] wait before rail one
        pbps_pkg::PBPS_UP_SW: begin
          if (tick) begin
            seq_cnt_r <= seq_cnt_r + 20'h00001;
          end
          if (tick && seq_cnt_r == SEQ_TICKS - 20'h00001) begin
            state_r <= pbps_pkg::PBPS_UP_ONE;
            r1_en_r <= 1'b1;
          end
        end
        pbps_pkg::PBPS_UP_ONE: begin
          state_r <= pbps_pkg::PBPS_ON;
          r2_en_r <= 1'b1;
        end
        // [RULE_17] power-down on stop request
        pbps_pkg::PBPS_ON: begin
          if (stop_req) begin
            state_r <= pbps_pkg::PBPS_OFF;
            sw_en_r <= 1'b0;
            r1_en_r <= 1'b0;
            r2_en_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Rails good
  // ----------------------------------------------------------------
  // [RULE_06] regulation flags qualify
  assign regs_ok = f_r[`PBPS_P_R1OK] && f_r[`PBPS_P_R2OK] &&
                   f_r[`PBPS_P_AOOK] && r1_en_r && r2_en_r;

  // [RULE_05] delay after regulation
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || !regs_ok) begin
      pg_cnt_r <= 20'h00000;
    end else if (tick) begin
      pg_cnt_r <= sat_inc(pg_cnt_r);
    end
  end

  // [RULE_20] drop on fault or rails off
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || !regs_ok) begin
      good_r <= 1'b0;
    end else if (pg_cnt_r >= PG_TICKS) begin
      good_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Loose status and control bits
  // ----------------------------------------------------------------
  // Registered pin-driven outputs
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      r3_en_r    <= 1'b0;
      ao_en_r    <= 1'b0;
      adapt_n_r  <= 1'b1;
      usb_open_r <= 1'b0;
      sel_r      <= 2'h0;
    end else begin
      // [RULE_07] rail three on own enable
      r3_en_r    <= f_r[`PBPS_P_EN3];
      // [RULE_08] always-on outside lockout
      ao_en_r    <= !f_r[`PBPS_P_UNDERVOLTAGE_LOCKOUT];
      // [RULE_12] adapter present indication
      adapt_n_r  <= !f_r[`PBPS_P_ADAPT];
      // [RULE_11] open the USB path
      usb_open_r <= f_r[`PBPS_P_ADAPT];
      // [RULE_14] low reset default selection
      sel_r      <= {f_r[`PBPS_P_SEL1], f_r[`PBPS_P_SEL0]};
    end
  end

  // ----------------------------------------------------------------
  // Serial port and register access
  // ----------------------------------------------------------------
  // [RULE_10] one bit per serial clock
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || f_r[`PBPS_P_LUV]) begin
      scl_prev_r <= 1'b0;
      shift_r    <= 8'h00;
      bit_cnt_r  <= 4'h0;
    end else begin
      scl_prev_r <= f_r[`PBPS_P_SCL];
      if (f_r[`PBPS_P_SCL] && !scl_prev_r) begin
        shift_r   <= {shift_r[6:0], f_r[`PBPS_P_SDA]};
        bit_cnt_r <= (bit_cnt_r == `PBPS_SER_BITS - 4'h1) ? 4'h0
                     : bit_cnt_r + 4'h1;
      end
    end
  end

  // [RULE_09] logic undervoltage clears registers
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || f_r[`PBPS_P_LUV]) begin
      ctrl_r <= 8'h00;
      ser_r  <= 8'h00;
    end else begin
      if (REG_WR_I && REG_ADDR_I == `PBPS_REG_CTRL) begin
        ctrl_r <= REG_WDATA_I;
      end
      if (f_r[`PBPS_P_SCL] && !scl_prev_r &&
          bit_cnt_r == `PBPS_SER_BITS - 4'h1) begin
        ser_r <= {shift_r[6:0], f_r[`PBPS_P_SDA]};
      end else if (REG_WR_I && REG_ADDR_I == `PBPS_REG_SERIAL) begin
        ser_r <= REG_WDATA_I;
      end
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rdata_r <= 8'h00;
    end else if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        `PBPS_REG_CTRL:   rdata_r <= ctrl_r;
        `PBPS_REG_STATUS: rdata_r <= {good_r, stat_r, r2_en_r, r1_en_r,
                                      sw_en_r, 1'b0, state_r};
        `PBPS_REG_SERIAL: rdata_r <= ser_r;
        default:          rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA_O           = rdata_r;
  assign SWITCHED_LINEAR_EN_O  = sw_en_r;
  assign RAIL_ONE_EN_O         = r1_en_r;
  assign RAIL_TWO_EN_O         = r2_en_r;
  assign RAIL_THREE_EN_O       = r3_en_r;
  assign ALWAYS_ON_LINEAR_EN_O = ao_en_r;
  assign BUTTON_STAT_O         = 1'b0;
  assign BUTTON_STAT_OE_O      = stat_r;
  assign RAILS_GOOD_O          = 1'b0;
  assign RAILS_GOOD_OE_O       = !good_r || rst_pulse_r;
  assign ADAPTER_PRESENT_N_O   = adapt_n_r;
  assign USB_PATH_OPEN_O       = usb_open_r;
  assign INPUT_LIMIT_SEL_O     = sel_r;
  // [RULE_13] gate off straight from the pin
  assign INPUT_PASS_GATE_O     = !OVERVOLTAGE_SENSE_IN_I && !RST_I;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  chk_order_one: assert property ($rose(r1_en_r) |-> sw_en_r) // [RULE_02]
    else $error("rail one before switched rail");
  chk_order_two: assert property ($rose(r2_en_r) |-> $past(r1_en_r)) // [RULE_02]
    else $error("rail two before rail one");
  chk_seq_wait: assert property ($rose(r1_en_r) |-> // [RULE_18]
    $past(seq_cnt_r) == SEQ_TICKS - 20'h00001 && $past(tick))
    else $error("rail one enabled early");
  chk_good_delay: assert property ($rose(good_r) |-> // [RULE_05]
    $past(pg_cnt_r) >= PG_TICKS && $past(regs_ok))
    else $error("rails good rose early");
  chk_good_drop: assert property (!regs_ok |=> !good_r) // [RULE_20]
    else $error("rails good held on fault");
  chk_reset_pulse: assert property ($rose(rst_pulse_r) |-> // [RULE_16]
    RAILS_GOOD_OE_O [*8])
    else $error("reset pulse not driven");
  chk_gate_off: assert property (OVERVOLTAGE_SENSE_IN_I |-> // [RULE_13]
    !INPUT_PASS_GATE_O)
    else $error("pass gate on in overvoltage");
  chk_uv_clear: assert property (f_r[`PBPS_P_LUV] |=> // [RULE_09]
    ctrl_r == 8'h00 && ser_r == 8'h00)
    else $error("registers kept under undervoltage");
  chk_aon_lockout: assert property (f_r[`PBPS_P_UNDERVOLTAGE_LOCKOUT] |=> // [RULE_08]
    !ao_en_r && !sw_en_r)
    else $error("rail on during lockout");
  chk_stat_deb: assert property ($rose(stat_r) |-> // [RULE_04]
    $past(btn_cnt_r) >= DEB_TICKS)
    else $error("button status not debounced");
  chk_adapt_flag: assert property (f_r[`PBPS_P_ADAPT] |=> // [RULE_12]
    !ADAPTER_PRESENT_N_O && USB_PATH_OPEN_O)
    else $error("adapter not flagged");

  cov_power_on: cover property (state_r == pbps_pkg::PBPS_UP_ONE ##1
    state_r == pbps_pkg::PBPS_ON);
  cov_good_rise: cover property ($rose(good_r));
  cov_long_press: cover property ($rose(rst_pulse_r));

endmodule // pbps_top
`default_nettype wire

// ==== pbps_map.svh ====
// Constants for the pushbutton power sequencer
// ----------------------------------------------------------------
// Overview of operation
// [RULE_01] Host holds hold-power high to stay on
// [RULE_02] Power-up order: switched linear, one, two
// [RULE_03] Button idles high, low means pressed
// [RULE_04] Button status is debounced button copy
// [RULE_05] Rails good rises 230 ms after regulation
// [RULE_06] Rails good uses rail one, two, always-on
// [RULE_07] Rail three follows only its enable input
// [RULE_08] Always-on rail on except output-supply lockout
// [RULE_09] Logic supply undervoltage clears serial registers
// [RULE_10] One serial bit shifted per clock pulse
// [RULE_11] Adapter above threshold opens USB path
// [RULE_12] Adapter present output low when detected
// [RULE_13] Overvoltage turns pass gate off at once
// [RULE_14] Limit selects default low when unconnected
// [RULE_15] Power-up after button low 50 ms
// [RULE_16] 14 s press gives 1.8 ms reset
// [RULE_17] Power-down after hold-power low 50 ms
// [RULE_18] 14.5 ms from switched rail to one
// [RULE_19] All delays counted from one timebase
// [RULE_20] Rails good drops on fault or off
// ----------------------------------------------------------------
`ifndef PBPS_MAP_SVH
`define PBPS_MAP_SVH

// Timing in microseconds, clock in MHz
`define PBPS_CLK_MHZ      10
`define PBPS_T_TICK_US    100
`define PBPS_T_DEB_US     50000
`define PBPS_T_REL_US     900
`define PBPS_T_PG_US      230000
`define PBPS_T_LONG_US    14000000
`define PBPS_T_RSTPW_US   1800
`define PBPS_T_SEQ_US     14500
`define PBPS_TICK_CYC     (`PBPS_T_TICK_US * `PBPS_CLK_MHZ)
`define PBPS_DEB_TICKS    (`PBPS_T_DEB_US / `PBPS_T_TICK_US)
`define PBPS_REL_TICKS    (`PBPS_T_REL_US / `PBPS_T_TICK_US)
`define PBPS_PG_TICKS     (`PBPS_T_PG_US / `PBPS_T_TICK_US)
`define PBPS_LONG_TICKS   (`PBPS_T_LONG_US / `PBPS_T_TICK_US)
`define PBPS_RSTPW_TICKS  (`PBPS_T_RSTPW_US / `PBPS_T_TICK_US)
`define PBPS_SEQ_TICKS    (`PBPS_T_SEQ_US / `PBPS_T_TICK_US)

// Pin vector positions
`define PBPS_P_BTN_N      0
`define PBPS_P_HOLD       1
`define PBPS_P_EN3        2
`define PBPS_P_ADAPT      3
`define PBPS_P_OV         4
`define PBPS_P_R1OK       5
`define PBPS_P_R2OK       6
`define PBPS_P_AOOK       7
`define PBPS_P_LUV        8
`define PBPS_P_UNDERVOLTAGE_LOCKOUT       9
`define PBPS_P_SEL0       10
`define PBPS_P_SEL1       11
`define PBPS_P_SCL        12
`define PBPS_P_SDA        13
`define PBPS_NPINS        14

// Register indices and fields
`define PBPS_REG_CTRL     2'h0
`define PBPS_REG_STATUS   2'h1
`define PBPS_REG_SERIAL   2'h2
`define PBPS_CTRL_SOFTOFF 0
`define PBPS_SER_BITS     4'h8

`endif

// ==== pbps_pkg.sv ====
// Types for the pushbutton power sequencer
package pbps_pkg;
  typedef enum logic [1:0] {
    PBPS_OFF,
    PBPS_UP_SW,
    PBPS_UP_ONE,
    PBPS_ON
  } pbps_state_type;
endpackage : pbps_pkg

// ==== pbps_partner.sv ====
// Host processor, pushbutton and regulator flag model for the sequencer bench
`timescale 1ns/1ps
`default_nettype none
module pbps_partner (
  input  wire logic       clk_i,
  input  wire logic       press_i,
  input  wire logic       hold_i,
  input  wire logic       fault_i,
  input  wire logic       one_en_i,
  input  wire logic       two_en_i,
  input  wire logic       ao_en_i,
  output logic            button_n_o,
  output logic            hold_o,
  output logic            one_ok_o,
  output logic            two_ok_o,
  output logic            ao_ok_o,
  output var logic        sclk_o,
  output var logic        sdat_o
);
  // ----------------------------------------------------------------
  // Pushbutton and host level
  // ----------------------------------------------------------------
  // Pull-up idles high, switch grounds
  assign button_n_o = !press_i;
  assign hold_o = hold_i;

  // Regulators reach regulation one cycle after enable
  always_ff @(posedge clk_i) begin
    one_ok_o <= one_en_i && !fault_i;
    two_ok_o <= two_en_i;
    ao_ok_o  <= ao_en_i;
  end

  // ----------------------------------------------------------------
  // Serial sender
  // ----------------------------------------------------------------
  initial begin
    sclk_o = 1'b0;
    sdat_o = 1'b1;
  end

  // One bit per clock pulse, MSB first
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      repeat (2) @(posedge clk_i);
      sdat_o <= b[i];
      repeat (6) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    sdat_o <= !b[0]; // Line driven to inverse of last bit, shows no stale bit
  endtask
endmodule // pbps_partner
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the pushbutton power sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int TICK = 1000;
  localparam int DEB  = 3;
  localparam int PG   = 5;
  localparam int LONG = 10;
  localparam int SEQ  = 2;
  logic       clk, rst, press, hold, fault, en3, adapt, ov, luv, undervoltage_lockout, sel0, sel1, wr, rd;
  logic [1:0] addr, sel_o;
  logic [7:0] wdata, rdata, d;
  logic       btn_n, hold_p, one_ok, two_ok, ao_ok, sclk, sdat, bs, rg, apn, usb, gate;
  logic       sw_en, one_en, two_en, three_en, ao_en, bs_oe, rg_oe;
  logic [5:0] obs;
  int         err_count, checks, n, m;

  assign obs = {rg_oe, bs_oe, ao_en, two_en, one_en, sw_en};

  pbps_partner u_host (.clk_i(clk), .press_i(press), .hold_i(hold), .fault_i(fault), .one_en_i(one_en),
    .two_en_i(two_en), .ao_en_i(ao_en), .button_n_o(btn_n), .hold_o(hold_p), .one_ok_o(one_ok),
    .two_ok_o(two_ok), .ao_ok_o(ao_ok), .sclk_o(sclk), .sdat_o(sdat));

  pbps_top #(.DEB_TICKS(20'(DEB)), .PG_TICKS(20'(PG)), .LONG_TICKS(20'(LONG)), .SEQ_TICKS(20'(SEQ))) u_dut (
    .CORE_CLK_I(clk), .RST_I(rst), .BUTTON_N_I(btn_n), .HOLD_POWER_IN_I(hold_p),
    .RAIL3_SWITCH_ENABLE_I(en3), .ADAPTER_DETECT_I(adapt), .OVERVOLTAGE_SENSE_IN_I(ov),
    .RAIL_ONE_IN_REG_I(one_ok), .RAIL_TWO_IN_REG_I(two_ok), .ALWAYS_ON_IN_REG_I(ao_ok),
    .LOGIC_SUPPLY_UV_I(luv), .UNDERVOLTAGE_LOCKOUT_I(undervoltage_lockout), .INPUT_LIMIT_SEL0_I(sel0),
    .INPUT_LIMIT_SEL1_I(sel1), .SERIAL_CLK_I(sclk), .SERIAL_DATA_I(sdat), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .SWITCHED_LINEAR_EN_O(sw_en),
    .RAIL_ONE_EN_O(one_en), .RAIL_TWO_EN_O(two_en), .RAIL_THREE_EN_O(three_en),
    .ALWAYS_ON_LINEAR_EN_O(ao_en), .BUTTON_STAT_O(bs), .BUTTON_STAT_OE_O(bs_oe), .RAILS_GOOD_O(rg),
    .RAILS_GOOD_OE_O(rg_oe), .ADAPTER_PRESENT_N_O(apn), .USB_PATH_OPEN_O(usb),
    .INPUT_PASS_GATE_O(gate), .INPUT_LIMIT_SEL_O(sel_o));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_rng(input string what, input int v, input int lo, input int hi);
    check(what, 32'(v >= lo && v <= hi), 32'h1);
  endtask

  // Waits for an observed output to reach a level, counting cycles
  task automatic wait_for(input int i, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (obs[i] !== v && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic finish_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_pins;
    @(posedge clk);
    ov <= 1'b1;
    #1 check("pass gate", gate, 1'b0);
    @(posedge clk);
    ov <= 1'b0;
    adapt <= 1'b1;
    sel1 <= 1'b1;
    en3 <= 1'b1;
    settle(8);
    check("pass gate", gate, 1'b1);
    check("adapter n", apn, 1'b0);
    check("usb path", usb, 1'b1);
    check("limit sel", sel_o, 2'h2);
    check("rail three", three_en, 1'b1);
    @(posedge clk);
    adapt <= 1'b0;
    sel0 <= 1'b1;
    sel1 <= 1'b0;
    en3 <= 1'b0;
    settle(8);
    check("adapter n", apn, 1'b1);
    check("limit sel", sel_o, 2'h1);
    check("stat pin level", bs, 1'b0);
    check("good pin level", rg, 1'b0);
    check("rail three", three_en, 1'b0);
  endtask

  task automatic t_hold_up;
    @(posedge clk);
    hold <= 1'b1;
    wait_for(0, 1'b1, (DEB + 1) * TICK + 10, n);
    check_rng("hold start", n, (DEB - 1) * TICK, DEB * TICK + 10);
    check("rail one early", one_en, 1'b0);
    wait_for(1, 1'b1, (SEQ + 1) * TICK, n);
    check_rng("rail one delay", n, (SEQ - 1) * TICK, SEQ * TICK + 2);
    check("rail two early", two_en, 1'b0);
    settle(1);
    check("rail two", two_en, 1'b1);
    wait_for(5, 1'b0, (PG + 1) * TICK, n);
    check_rng("good delay", n, (PG - 1) * TICK, PG * TICK + 10);
    check("rail three idle", three_en, 1'b0);
    @(posedge clk);
    fault <= 1'b1;
    settle(8);
    check("good on fault", rg_oe, 1'b1);
    @(posedge clk);
    fault <= 1'b0;
    wait_for(5, 1'b0, (PG + 1) * TICK, n);
    check("good again", rg_oe, 1'b0);
  endtask

  task automatic t_button;
    @(posedge clk);
    press <= 1'b1;
    wait_for(4, 1'b1, TICK, n);
    check("short press", bs_oe, 1'b0);
    @(posedge clk);
    press <= 1'b0;
    settle(2 * TICK);
    @(posedge clk);
    press <= 1'b1;
    wait_for(4, 1'b1, (DEB + 1) * TICK + 10, n);
    check_rng("stat press", n, (DEB - 1) * TICK, DEB * TICK + 10);
    wait_for(5, 1'b1, LONG * TICK, m);
    check_rng("long press", n + m, (LONG - 1) * TICK, LONG * TICK + 20);
    wait_for(5, 1'b0, 20 * TICK, n);
    check_rng("reset width", n, 17 * TICK, 18 * TICK + 10);
    settle(3 * TICK);
    check("one pulse", rg_oe, 1'b0);
    @(posedge clk);
    press <= 1'b0;
    wait_for(4, 1'b0, 11 * TICK, n);
    check_rng("stat release", n, 8 * TICK, 9 * TICK + 10);
  endtask

  task automatic t_hold_down;
    @(posedge clk);
    hold <= 1'b0;
    wait_for(0, 1'b0, (DEB + 2) * TICK, n);
    check_rng("hold stop", n, (DEB - 1) * TICK, DEB * TICK + 10);
    check("rails off", {one_en, two_en}, 2'h0);
    settle(3);
    check("good off", rg_oe, 1'b1);
  endtask

  task automatic t_button_up;
    @(posedge clk);
    press <= 1'b1;
    wait_for(0, 1'b1, (DEB + 1) * TICK + 10, n);
    check_rng("button start", n, (DEB - 1) * TICK, DEB * TICK + 10);
    @(posedge clk);
    press <= 1'b0;
    reg_rd(2'h1, d);
    check("state", d[1:0], pbps_pkg::PBPS_UP_SW);
    wait_for(2, 1'b1, (SEQ + 1) * TICK, n);
    reg_wr(2'h0, 8'h01);
    wait_for(0, 1'b0, 20, n);
    check("soft off", obs[2:0], 3'h0);
  endtask

  task automatic t_serial_uv;
    u_host.send_byte(8'ha5);
    settle(10);
    reg_rd(2'h2, d);
    check("serial byte", d, 8'ha5);
    settle(1);
    check("read idle", rdata, 8'h00);
    reg_rd(2'h3, d);
    check("unmapped", d, 8'h00);
    reg_wr(2'h2, 8'h3c);
    reg_rd(2'h2, d);
    check("serial write", d, 8'h3c);
    @(posedge clk);
    luv <= 1'b1;
    settle(8);
    reg_wr(2'h0, 8'h01);
    @(posedge clk);
    luv <= 1'b0;
    settle(8);
    reg_rd(2'h0, d);
    check("ctrl cleared", d, 8'h00);
    reg_rd(2'h2, d);
    check("serial cleared", d, 8'h00);
  endtask

  task automatic t_lockout;
    @(posedge clk);
    undervoltage_lockout <= 1'b1;
    settle(8);
    check("always on lockout", ao_en, 1'b0);
    @(posedge clk);
    undervoltage_lockout <= 1'b0;
    settle(8);
    check("always on", ao_en, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #9000000;
    err_count++;
    finish_test();
  end

  initial begin
    {rst, press, hold, fault, en3, adapt, ov, luv, undervoltage_lockout, sel0, sel1, wr, rd} = 13'h1000;
    addr = 2'h0;
    wdata = 8'h00;
    err_count = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    #1 check("gate in reset", gate, 1'b0);
    check("good in reset", rg_oe, 1'b1);
    @(posedge clk);
    rst <= 1'b0;
    settle(3);
    check("always on", ao_en, 1'b1);
    t_pins();
    t_hold_up();
    t_button();
    t_hold_down();
    t_button_up();
    t_serial_uv();
    t_lockout();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
